// ---- hdl/umpc_pin_drive.sv ----
// resolves one pin's function, data and pulls into pad controls
module umpc_pin_drive (
    input  wire umpc_pkg::umpc_drv_e drv,
    input  wire logic                data,
    input  wire logic                pu_en,
    input  wire logic                pd_en,
    output umpc_pkg::umpc_pin_s      pin
);

    // pulls act only on inputs; pull-up beats pull-down
    always_comb begin
        pin.out_val   = 1'b1;
        pin.oe_n      = 1'b1;
        pin.pull_up   = 1'b0;
        pin.pull_down = 1'b0;
        case (drv)
            umpc_pkg::DRV_PP: begin
                pin.out_val = data;
                pin.oe_n    = 1'b0;
            end
            // open drain only ever drives low
            umpc_pkg::DRV_OD: begin
                pin.out_val = 1'b0;
                pin.oe_n    = data;
            end
            default: begin
                pin.pull_up   = pu_en;
                pin.pull_down = pd_en & ~pu_en;
            end
        endcase
    end

endmodule // umpc_pin_drive

// ---- hdl/umpc_pkg.sv ----
package umpc_pkg;

    // register word indices; printed offsets are not multiples of four, so byte address is index * 4
    localparam logic [6:0] IDX_RTS_SETUP  = 7'h25;
    localparam logic [6:0] IDX_CTS_SETUP  = 7'h26;
    localparam logic [6:0] IDX_DIR_SETUP  = 7'h27;
    localparam logic [6:0] IDX_TXT_SETUP  = 7'h28;
    localparam logic [6:0] IDX_GPIO_OUT   = 7'h30;
    localparam logic [6:0] IDX_PIN_STATE  = 7'h31;
    localparam int         ADDR_W         = 9;

    // field positions inside each 8-bit setting
    localparam int         PULLUP_BIT     = 7;
    localparam int         PULLDOWN_BIT   = 6;
    localparam logic [7:0] SETUP_RESET    = 8'h00;
    localparam logic [7:0] RTS_WMASK      = 8'hC7;
    localparam logic [7:0] OTHER_WMASK    = 8'hC3;
    localparam logic [3:0] GPIO_OUT_RESET = 4'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // request-to-send pin function codes
    localparam logic [2:0] RTS_GPIN       = 3'h0;
    localparam logic [2:0] RTS_GPOUT_PP   = 3'h1;
    localparam logic [2:0] RTS_GPOUT_OD   = 3'h2;
    localparam logic [2:0] RTS_FUNC_OD    = 3'h3;
    localparam logic [2:0] RTS_FUNC_PP    = 3'h4;

    // two-bit pin function codes
    localparam logic [1:0] SEL_GPIN       = 2'h0;
    localparam logic [1:0] SEL_GPOUT_OD   = 2'h1;
    localparam logic [1:0] SEL_GPOUT_PP   = 2'h2;
    localparam logic [1:0] SEL_FUNC       = 2'h3;

    // drive style resolved from a setting
    typedef enum logic [1:0] {
        DRV_IN = 2'h0,
        DRV_OD = 2'h1,
        DRV_PP = 2'h2
    } umpc_drv_e;

    // one pin's resolved control: what to drive and how
    typedef struct packed {
        logic      out_val;
        logic      oe_n;
        logic      pull_up;
        logic      pull_down;
    } umpc_pin_s;

    // avalon slave response group
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } umpc_bus_s;

endpackage : umpc_pkg

// ---- hdl/umpc_top.sv ----
module umpc_top (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [8:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        UART_RTS_N,
    input  wire logic        UART_TX_ACTIVE,
    input  wire logic        UART_HD_TX_EN,
    output logic             UART_CTS_N,
    input  wire logic [3:0]  PIN_IN,
    output logic [3:0]       PIN_OUT,
    output logic [3:0]       PIN_OE_N,
    output logic [3:0]       PIN_PULL_UP,
    output logic [3:0]       PIN_PULL_DOWN
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0]          rts_setup;
        logic [7:0]          cts_setup;
        logic [7:0]          dir_setup;
        logic [7:0]          txt_setup;
        logic [3:0]          gpio_out;
        logic [3:0]          sync1;
        logic [3:0]          sync2;
        logic                act1;
        logic                act2;
        logic                act3;
        logic                toggle;
        umpc_pkg::umpc_bus_s bus;
        logic                bus_done;
        logic [3:0]          pad_out;
        logic [3:0]          pad_oe_n;
        logic [3:0]          pad_pu;
        logic [3:0]          pad_pd;
        logic                cts_n;
    } umpc_state_s;

    umpc_state_s          st_reg;
    umpc_state_s          st_next;
    umpc_pkg::umpc_drv_e  drv    [4];
    logic [3:0]           data;
    umpc_pkg::umpc_pin_s  pin    [4];
    logic [6:0]           idx;
    logic                 access;

    // merge byte lane 0 under the writable-bit mask
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wd,
                                              input logic be, input logic [7:0] mask);
        merge_byte = be ? (wd & mask) : old;
    endfunction

    // decode a two-bit function select; code 11 is the pin's special function
    function automatic umpc_pkg::umpc_drv_e sel2_drv(input logic [1:0] sel,
                                                     input logic func_is_out);
        case (sel)
            umpc_pkg::SEL_GPOUT_OD: sel2_drv = umpc_pkg::DRV_OD;
            umpc_pkg::SEL_GPOUT_PP: sel2_drv = umpc_pkg::DRV_PP;
            umpc_pkg::SEL_FUNC:     sel2_drv = func_is_out ? umpc_pkg::DRV_PP : umpc_pkg::DRV_IN;
            default:                sel2_drv = umpc_pkg::DRV_IN;
        endcase
    endfunction

    assign idx    = AVS_ADDRESS[8:2];
    assign access = (AVS_READ | AVS_WRITE) & ~st_reg.bus_done;

    ////////////////////////////////////////////////////////////////////////////
    // pin function decode
    always_comb begin
        data = st_reg.gpio_out;
        case (st_reg.rts_setup[2:0])
            umpc_pkg::RTS_GPOUT_PP: drv[0] = umpc_pkg::DRV_PP;
            umpc_pkg::RTS_GPOUT_OD: drv[0] = umpc_pkg::DRV_OD;
            umpc_pkg::RTS_FUNC_OD: begin
                drv[0]  = umpc_pkg::DRV_OD;
                data[0] = UART_RTS_N;
            end
            umpc_pkg::RTS_FUNC_PP: begin
                drv[0]  = umpc_pkg::DRV_PP;
                data[0] = UART_RTS_N;
            end
            default: drv[0] = umpc_pkg::DRV_IN;
        endcase
        drv[1] = sel2_drv(st_reg.cts_setup[1:0], 1'b0);
        drv[2] = sel2_drv(st_reg.dir_setup[1:0], 1'b1);
        if (st_reg.dir_setup[1:0] == umpc_pkg::SEL_FUNC) begin
            data[2] = UART_HD_TX_EN;
        end
        drv[3] = sel2_drv(st_reg.txt_setup[1:0], 1'b1);
        if (st_reg.txt_setup[1:0] == umpc_pkg::SEL_FUNC) begin
            data[3] = st_reg.toggle;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            umpc_pin_drive u_drive (
                .drv   (drv[g]),
                .data  (data[g]),
                .pu_en (g == 0 ? st_reg.rts_setup[umpc_pkg::PULLUP_BIT] :
                        g == 1 ? st_reg.cts_setup[umpc_pkg::PULLUP_BIT] :
                        g == 2 ? st_reg.dir_setup[umpc_pkg::PULLUP_BIT] :
                                 st_reg.txt_setup[umpc_pkg::PULLUP_BIT]),
                .pd_en (g == 0 ? st_reg.rts_setup[umpc_pkg::PULLDOWN_BIT] :
                        g == 1 ? st_reg.cts_setup[umpc_pkg::PULLDOWN_BIT] :
                        g == 2 ? st_reg.dir_setup[umpc_pkg::PULLDOWN_BIT] :
                                 st_reg.txt_setup[umpc_pkg::PULLDOWN_BIT]),
                .pin   (pin[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next = st_reg;
        // pins and activity come from outside; two flops before use
        st_next.sync1 = PIN_IN;
        st_next.sync2 = st_reg.sync1;
        st_next.act1  = UART_TX_ACTIVE;
        st_next.act2  = st_reg.act1;
        st_next.act3  = st_reg.act2;
        // flip on each rising edge; edge taken past the synchroniser
        if (st_reg.act3 == 1'h0 && st_reg.act2 == 1'h1) begin
            st_next.toggle = ~st_reg.toggle;
        end
        for (int i = 0; i < 4; i++) begin
            st_next.pad_out[i]  = pin[i].out_val;
            st_next.pad_oe_n[i] = pin[i].oe_n;
            st_next.pad_pu[i]   = pin[i].pull_up;
            st_next.pad_pd[i]   = pin[i].pull_down;
        end
        // cts is the synced pad level, idle high when not routed
        st_next.cts_n = (st_reg.cts_setup[1:0] == umpc_pkg::SEL_FUNC) ? st_reg.sync2[1] : 1'b1;

        // one wait cycle, then answer; bus_done blocks a double take
        st_next.bus.waitrequest = 1'b1;
        st_next.bus_done        = 1'b0;
        if (access) begin
            st_next.bus.waitrequest = 1'b0;
            st_next.bus_done        = 1'b1;
            st_next.bus.readdata    = umpc_pkg::UNMAPPED_READ;
            if (AVS_WRITE) begin
                // reserved bits are masked so stray ones never land
                case (idx)
                    umpc_pkg::IDX_RTS_SETUP: st_next.rts_setup = merge_byte(st_reg.rts_setup,
                        AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0], umpc_pkg::RTS_WMASK);
                    umpc_pkg::IDX_CTS_SETUP: st_next.cts_setup = merge_byte(st_reg.cts_setup,
                        AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0], umpc_pkg::OTHER_WMASK);
                    umpc_pkg::IDX_DIR_SETUP: st_next.dir_setup = merge_byte(st_reg.dir_setup,
                        AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0], umpc_pkg::OTHER_WMASK);
                    umpc_pkg::IDX_TXT_SETUP: st_next.txt_setup = merge_byte(st_reg.txt_setup,
                        AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0], umpc_pkg::OTHER_WMASK);
                    umpc_pkg::IDX_GPIO_OUT: if (AVS_BYTEENABLE[0]) begin
                        st_next.gpio_out = AVS_WRITEDATA[3:0];
                    end
                    default: ;
                endcase
            end else begin
                case (idx)
                    umpc_pkg::IDX_RTS_SETUP: st_next.bus.readdata[7:0] = st_reg.rts_setup;
                    umpc_pkg::IDX_CTS_SETUP: st_next.bus.readdata[7:0] = st_reg.cts_setup;
                    umpc_pkg::IDX_DIR_SETUP: st_next.bus.readdata[7:0] = st_reg.dir_setup;
                    umpc_pkg::IDX_TXT_SETUP: st_next.bus.readdata[7:0] = st_reg.txt_setup;
                    umpc_pkg::IDX_GPIO_OUT:  st_next.bus.readdata[3:0] = st_reg.gpio_out;
                    umpc_pkg::IDX_PIN_STATE: st_next.bus.readdata[4:0] = {st_reg.toggle,
                                                                          st_reg.sync2};
                    default: ;
                endcase
            end
        end

        if (SRST) begin
            st_next                 = '0;
            st_next.rts_setup       = umpc_pkg::SETUP_RESET;
            st_next.cts_setup       = umpc_pkg::SETUP_RESET;
            st_next.dir_setup       = umpc_pkg::SETUP_RESET;
            st_next.txt_setup       = umpc_pkg::SETUP_RESET;
            st_next.gpio_out        = umpc_pkg::GPIO_OUT_RESET;
            st_next.pad_out         = 4'hF;
            st_next.pad_oe_n        = 4'hF;
            st_next.cts_n           = 1'b1;
            st_next.bus.waitrequest = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge CLK) begin
        st_reg <= st_next;
    end

    assign AVS_READDATA    = st_reg.bus.readdata;
    assign AVS_WAITREQUEST = st_reg.bus.waitrequest;
    assign UART_CTS_N      = st_reg.cts_n;
    assign PIN_OUT         = st_reg.pad_out;
    assign PIN_OE_N        = st_reg.pad_oe_n;
    assign PIN_PULL_UP     = st_reg.pad_pu;
    assign PIN_PULL_DOWN   = st_reg.pad_pd;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_rts_in_sel;
        st_reg.rts_setup[2:0] == 3'h0 || st_reg.rts_setup[2:0] > 3'h4;
    endsequence

    sequence s_act_rise;
        !st_reg.act3 && st_reg.act2;
    endsequence

    a_pullup_input: assert property (@(posedge CLK) disable iff (SRST)
        (drv[0] == umpc_pkg::DRV_IN && st_reg.rts_setup[7]) |=> PIN_PULL_UP[0])
        else $error("pull-up missing on input");
    a_pull_outputs: assert property (@(posedge CLK) disable iff (SRST)
        (drv[3] != umpc_pkg::DRV_IN) |=> !PIN_PULL_DOWN[3] && !PIN_PULL_UP[3])
        else $error("pull active on output");
    a_pull_priority: assert property (@(posedge CLK) disable iff (SRST)
        PIN_PULL_UP[1] |-> !PIN_PULL_DOWN[1])
        else $error("both pulls on");
    a_rts_reserved: assert property (@(posedge CLK) disable iff (SRST)
        st_reg.rts_setup[5:3] == 3'h0 && st_reg.cts_setup[5:2] == 4'h0)
        else $error("reserved bits stored");
    a_rts_func_pp: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.rts_setup[2:0] == 3'h4) ##1 (st_reg.rts_setup[2:0] == 3'h4)
        |-> !PIN_OE_N[0] && PIN_OUT[0] == $past(UART_RTS_N))
        else $error("rts push-pull wrong");
    a_rts_func_od: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.rts_setup[2:0] == 3'h3) |=> !PIN_OUT[0])
        else $error("rts open drain drives high");
    a_rts_undef_in: assert property (@(posedge CLK) disable iff (SRST)
        s_rts_in_sel |=> PIN_OE_N[0])
        else $error("rts undefined code drives");
    a_cts_route: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.cts_setup[1:0] != 2'h3) |=> UART_CTS_N)
        else $error("cts not idle");
    a_dir_pp: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.dir_setup[1:0] == 2'h3) |=> !PIN_OE_N[2])
        else $error("direction not driven");
    a_bus_answer: assert property (@(posedge CLK) disable iff (SRST)
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[0:1] !AVS_WAITREQUEST)
        else $error("bus answer late");
    a_bus_one_cycle: assert property (@(posedge CLK) disable iff (SRST)
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("bus answer held too long");

    // request-to-send pin, plain and uart uses
    a_rts_gpin_idle: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.rts_setup[2:0] == umpc_pkg::RTS_GPIN) |=> PIN_OE_N[0] && PIN_OUT[0])
        else $error("rts input pin driven");
    a_rts_gpout_pp: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.rts_setup[2:0] == umpc_pkg::RTS_GPOUT_PP)
        |=> !PIN_OE_N[0] && PIN_OUT[0] == $past(st_reg.gpio_out[0]))
        else $error("rts plain push-pull wrong");
    a_rts_gpout_od: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.rts_setup[2:0] == umpc_pkg::RTS_GPOUT_OD)
        |=> !PIN_OUT[0] && PIN_OE_N[0] == $past(st_reg.gpio_out[0]))
        else $error("rts plain open drain wrong");
    a_rts_od_follow: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.rts_setup[2:0] == umpc_pkg::RTS_FUNC_OD) |=> PIN_OE_N[0] == $past(UART_RTS_N))
        else $error("rts open drain not following uart");

    // clear-to-send pin
    a_cts_gpin_idle: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.cts_setup[1:0] == umpc_pkg::SEL_GPIN) |=> PIN_OE_N[1] && PIN_OUT[1])
        else $error("cts input pin driven");
    a_cts_gpout_od: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.cts_setup[1:0] == umpc_pkg::SEL_GPOUT_OD)
        |=> !PIN_OUT[1] && PIN_OE_N[1] == $past(st_reg.gpio_out[1]))
        else $error("cts plain open drain wrong");
    a_cts_gpout_pp: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.cts_setup[1:0] == umpc_pkg::SEL_GPOUT_PP)
        |=> !PIN_OE_N[1] && PIN_OUT[1] == $past(st_reg.gpio_out[1]))
        else $error("cts plain push-pull wrong");
    a_cts_func_in: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.cts_setup[1:0] == umpc_pkg::SEL_FUNC) |=> PIN_OE_N[1])
        else $error("cts flow input driven");
    a_cts_from_pad: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.cts_setup[1:0] == umpc_pkg::SEL_FUNC) |=> UART_CTS_N == $past(st_reg.sync2[1]))
        else $error("cts not following pad");

    // half-duplex direction pin
    a_dir_gpin_idle: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.dir_setup[1:0] == umpc_pkg::SEL_GPIN) |=> PIN_OE_N[2] && PIN_OUT[2])
        else $error("direction input pin driven");
    a_dir_gpout_od: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.dir_setup[1:0] == umpc_pkg::SEL_GPOUT_OD)
        |=> !PIN_OUT[2] && PIN_OE_N[2] == $past(st_reg.gpio_out[2]))
        else $error("direction plain open drain wrong");
    a_dir_gpout_pp: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.dir_setup[1:0] == umpc_pkg::SEL_GPOUT_PP)
        |=> !PIN_OE_N[2] && PIN_OUT[2] == $past(st_reg.gpio_out[2]))
        else $error("direction plain push-pull wrong");
    a_dir_func_data: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.dir_setup[1:0] == umpc_pkg::SEL_FUNC) |=> PIN_OUT[2] == $past(UART_HD_TX_EN))
        else $error("direction not following enable");

    // transmit toggle pin
    a_txt_gpin_idle: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.txt_setup[1:0] == umpc_pkg::SEL_GPIN) |=> PIN_OE_N[3] && PIN_OUT[3])
        else $error("toggle input pin driven");
    a_txt_gpout_od: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.txt_setup[1:0] == umpc_pkg::SEL_GPOUT_OD)
        |=> !PIN_OUT[3] && PIN_OE_N[3] == $past(st_reg.gpio_out[3]))
        else $error("toggle plain open drain wrong");
    a_txt_gpout_pp: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.txt_setup[1:0] == umpc_pkg::SEL_GPOUT_PP)
        |=> !PIN_OE_N[3] && PIN_OUT[3] == $past(st_reg.gpio_out[3]))
        else $error("toggle plain push-pull wrong");
    a_txt_func_pp: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.txt_setup[1:0] == umpc_pkg::SEL_FUNC)
        |=> !PIN_OE_N[3] && PIN_OUT[3] == $past(st_reg.toggle))
        else $error("toggle output wrong");

    // activity toggle flips once per synced rise and holds otherwise
    a_toggle_flip: assert property (@(posedge CLK) disable iff (SRST)
        s_act_rise |=> st_reg.toggle != $past(st_reg.toggle))
        else $error("toggle missed a rise");
    a_toggle_hold: assert property (@(posedge CLK) disable iff (SRST)
        (st_reg.act3 || !st_reg.act2) |=> $stable(st_reg.toggle))
        else $error("toggle moved without a rise");

    // pulls on the direction pin as well
    a_pulldown_input: assert property (@(posedge CLK) disable iff (SRST)
        (drv[2] == umpc_pkg::DRV_IN && st_reg.dir_setup[6] && !st_reg.dir_setup[7])
        |=> PIN_PULL_DOWN[2])
        else $error("pull-down missing on input");
    a_pullup_wins: assert property (@(posedge CLK) disable iff (SRST)
        (drv[2] == umpc_pkg::DRV_IN && st_reg.dir_setup[7])
        |=> PIN_PULL_UP[2] && !PIN_PULL_DOWN[2])
        else $error("pull-up did not win");

endmodule // umpc_top

// ---- tb/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic [8:0]  addr = 9'h000;
    logic        rd_en = 1'h0;
    logic        wr_en = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  ben = 4'hF;
    logic [31:0] rdata;
    logic        wait_req;
    logic        rts_n = 1'h1;
    logic        tx_act = 1'h0;
    logic        hd_en = 1'h0;
    logic        cts_n;
    logic [3:0]  pad, p_out, p_oe_n, p_pu, p_pd;
    logic [3:0]  ext_en = 4'h0;
    logic [3:0]  ext_val = 4'h0;
    logic [31:0] q;
    logic [1:0]  e;
    int          bad_count = 0;
    int          num_checks = 0;
    int          toggles = 0;

    always #12.5 clk = ~clk;

    umpc_top umpc_top_i (.CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(ben), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .UART_RTS_N(rts_n), .UART_TX_ACTIVE(tx_act),
        .UART_HD_TX_EN(hd_en), .UART_CTS_N(cts_n), .PIN_IN(pad), .PIN_OUT(p_out),
        .PIN_OE_N(p_oe_n), .PIN_PULL_UP(p_pu), .PIN_PULL_DOWN(p_pd));
    umpc_line_model umpc_line_model_i (.clk(clk), .pin_out(p_out), .pin_oe_n(p_oe_n),
        .pull_up(p_pu), .pull_down(p_pd), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                       output logic [31:0] got);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        wr_en <= wr;
        rd_en <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'h0 && n < 20);
        if (n >= 20) begin
            bad_count++;
            $display("wrong value waitrequest expected 0 seen 1");
        end
        // read data stands at the same edge that shows the answer
        got = rdata;
        wr_en <= 1'h0;
        rd_en <= 1'h0;
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        bus(1'h1, idx, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [6:0] idx, input logic [7:0] exp);
        bus(1'h0, idx, 8'h00, q);
        check(what, {24'h0, exp}, q);
    endtask

    // pad controls lag by a few registers; sample mid-cycle
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask

    task automatic pulse();
        @(posedge clk);
        tx_act <= 1'h1;
        repeat (4) @(posedge clk);
        tx_act <= 1'h0;
        repeat (4) @(posedge clk);
        toggles++;
    endtask

    // pin table
    // result is {oe_n, out}; plain data is d, rts and direction uart sources carry ~d, the toggle pin carries toggles[0]
    function automatic logic [1:0] expect_pin(int p, logic [2:0] c, logic d);
        if (p == 0) begin
            case (c)
                3'h1: return {1'h0, d};
                3'h2: return {d, 1'h0};
                3'h3: return {~d, 1'h0};
                3'h4: return {1'h0, ~d};
                default: return 2'h3;
            endcase
        end
        case (c[1:0])
            2'h1: return {d, 1'h0};
            2'h2: return {1'h0, d};
            2'h3: return p == 1 ? 2'h3 : {1'h0, p == 2 ? ~d : toggles[0]};
            default: return 2'h3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the full run needs about 1,300 cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("wrong value watchdog expected done seen hang");
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        for (int r = 0; r < 4; r++)
            rd_chk("setup reset", 7'(7'h25 + r), 8'h00);
        check("pads after reset", 32'h0000_00FF, 32'({p_oe_n, p_out}));
        wr(7'h10, 8'h55);
        rd_chk("unmapped", 7'h10, 8'h00);
        ben <= 4'hE;
        wr(7'h25, 8'h81);
        ben <= 4'hF;
        rd_chk("lane 0 off", 7'h25, 8'h00);
        for (int r = 0; r < 4; r++) begin
            wr(7'(7'h25 + r), 8'hFF);
            rd_chk("reserved bits", 7'(7'h25 + r), r == 0 ? 8'hC7 : 8'hC3);
            wr(7'(7'h25 + r), 8'h00);
        end
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            for (int m = 1; m < 4; m++) begin
                wr(7'(7'h25 + p), 8'(m << 6));
                settle();
                check("pull up", 32'(m >> 1), 32'(p_pu[p]));
                check("pull down", 32'(m == 1), 32'(p_pd[p]));
                wr(7'(7'h25 + p), 8'((m << 6) | (p == 0 ? 1 : 2)));
                settle();
                check("pulls on output", 32'h0, 32'({p_pu[p], p_pd[p]}));
            end
            wr(7'(7'h25 + p), 8'h00);
        end
        $display("test pulls done");
        ext_en <= 4'h2;
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < (p == 0 ? 8 : 4); c++) begin
                for (int d = 0; d < 2; d++) begin
                    wr(7'h30, {4'h0, {4{d[0]}}});
                    rts_n <= ~d[0];
                    hd_en <= ~d[0];
                    ext_val <= {4{d[0]}};
                    // flow pins set as a pair
                    if (p == 0 && (c == 3 || c == 4))
                        wr(7'h26, 8'h03);
                    if (p == 1 && c == 3)
                        wr(7'h25, 8'h04);
                    wr(7'(7'h25 + p), 8'(c));
                    pulse();
                    settle();
                    e = expect_pin(p, 3'(c), d[0]);
                    check("pad oe_n", 32'(e[1]), 32'(p_oe_n[p]));
                    check("pad out", 32'(e[0]), 32'(p_out[p]));
                    if (p == 1)
                        check("cts to uart", 32'(c == 3 ? d[0] : 1), 32'(cts_n));
                end
                wr(7'h25, 8'h00);
                wr(7'h26, 8'h00);
                wr(7'(7'h25 + p), 8'h00);
            end
        end
        $display("test functions done");
        ext_en <= 4'hF;
        ext_val <= 4'hA;
        settle();
        bus(1'h0, 7'h31, 8'h00, q);
        check("pin state", 32'({toggles[0], 4'hA}), 32'(q[4:0]));
        // a second reset mid-run must clear the settings again
        wr(7'h27, 8'h81);
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        rd_chk("setup after reset", 7'h27, 8'h00);
        $display("test state and reset done");
        report_and_stop();
    end
endmodule // tb

// ---- tb/umpc_line_model.sv ----
// far side of the four pads: transceiver lines with optional external drivers
module umpc_line_model (
    input  wire logic       clk,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe_n,
    input  wire logic [3:0] pull_up,
    input  wire logic [3:0] pull_down,
    input  wire logic [3:0] ext_en,
    input  wire logic [3:0] ext_val,
    output logic [3:0]      pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_pat = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // an unpulled, undriven pad wanders so a stale level never passes
    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    // device drive wins over the far side; contention is not modelled
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pin_oe_n[i])
                pad[i] = pin_out[i];
            else if (ext_en[i])
                pad[i] = ext_val[i];
            else if (pull_up[i])
                pad[i] = 1'h1;
            else if (pull_down[i])
                pad[i] = 1'h0;
            else
                pad[i] = float_pat;
        end
    end
endmodule // umpc_line_model
